// ==== mad_pkg.sv ====
// Constants for the program and data address-space decoder
package mad_pkg;
    localparam int PADDR_W = 24;
    localparam int PC_W = 23;
    localparam int DADDR_W = 16;
    localparam int WORD_W = 16;
    localparam logic [23:0] USER_TOP = 24'h7FFFFF;
    localparam logic [23:0] RESET_ADDR = 24'h000000;
    localparam logic [23:0] RESET_TARGET_ADDR = 24'h000002;
    localparam logic [23:0] VECTOR_END = 24'h000200;
    localparam logic [23:0] IVT_START = 24'h000004;
    localparam logic [23:0] IVT_END = 24'h0000FF;
    localparam logic [23:0] AIVT_START = 24'h000100;
    localparam logic [23:0] AIVT_END = 24'h0001FF;
    localparam logic [23:0] CFG_WORD1_LARGE = 24'h00ABFC;
    localparam logic [23:0] CFG_WORD2_LARGE = 24'h00ABFE;
    localparam logic [23:0] CFG_WORD1_SMALL = 24'h002BFC;
    localparam logic [23:0] CFG_WORD2_SMALL = 24'h002BFE;
    localparam logic [23:0] PC_STEP = 24'h000002;
    localparam int TBLPG_CFG_BIT = 7;
    localparam int EA_PSV_BIT = 15;
    localparam int CPUCTL_VIS_BIT = 2;
    localparam logic [15:0] DATA_IMPL_TOP = 16'h1FFF;
    localparam int DMEM_WORDS = 4096;
    localparam logic [15:0] CFG1_RESET = 16'hFFFF;
    localparam logic [15:0] CFG2_RESET = 16'hFFFF;
    typedef enum logic [1:0] {
        MAD_LOAD_IDLE = 2'b00,
        MAD_LOAD_W1 = 2'b01,
        MAD_LOAD_W2 = 2'b10,
        MAD_LOAD_DONE = 2'b11
    } mad_load_t;
endpackage

// ==== mad_byte_lane.sv ====
// Byte lane selection for data reads
`timescale 1ns/10ps
module mad_byte_lane
    import mad_pkg::*;
(
    input wire logic [15:0] word_in,
    input wire logic byte_op,
    input wire logic odd_addr,
    output logic [15:0] data_out
);
    wire [7:0] lane = odd_addr ? word_in[15:8] : word_in[7:0];
    // Byte lands in the low byte of the data path
    assign data_out = byte_op ? {8'h00, lane} : word_in;
endmodule

// ==== mad_data_agu.sv ====
// One data-space address generation unit: decode of a byte address
`timescale 1ns/10ps
module mad_data_agu
    import mad_pkg::*;
(
    input wire logic [15:0] ea,
    input wire logic valid,
    input wire logic psv_en,
    output logic hit_ram,
    output logic hit_psv,
    output logic hit_none,
    output logic [11:0] word_idx
);
    wire upper = ea[EA_PSV_BIT];
    assign hit_ram = valid && !upper && (ea <= DATA_IMPL_TOP);
    assign hit_psv = valid && upper && psv_en;
    assign hit_none = valid && !hit_ram && !hit_psv;
    assign word_idx = ea[12:1];
endmodule

// ==== mad_decoder.sv ====
// Program and data address-space decoder with configuration load
`timescale 1ns/10ps
// Contract
// - Program address is 24 bits from PC/table
// - User accesses limited to lower half
// - Table page bit 7 reaches config space
// - Location is 24 bits, top byte unimplemented
// - Lower word even, upper word odd
// - Lower-word aligned, PC steps by two
// - Reset starts at zero, target at two
// - Region below 000200h reserved for vectors
// - Primary and alternate vector tables decoded
// - Top two words hold configuration
// - Config words copied on every reset
// - Packed bits scattered to config registers
// - Separate read and write address units
// - Data address is 16-bit byte address
// - Bit 15 selects RAM or visibility window
// - Outside 8 Kbytes reads return zero
// - Window active only with visibility enable
// - Byte read selects lane by address LSB
module mad_decoder
    import mad_pkg::*;
#(
    parameter bit LARGE_MEM = 1'b1
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [22:0] pc,
    input wire logic pc_advance,
    input wire logic pc_back,
    input wire logic pc_load,
    input wire logic [22:0] pc_load_value,
    input wire logic tbl_req,
    input wire logic tbl_write,
    input wire logic tbl_upper,
    input wire logic [7:0] table_page_register,
    input wire logic [15:0] tbl_offset,
    input wire logic [15:0] tbl_wdata,
    input wire logic [15:0] psv_page_addr,
    input wire logic [15:0] cpu_control_register,
    input wire logic [23:0] pmem_rdata,
    input wire logic pmem_rvalid,
    input wire logic rd_req,
    input wire logic rd_byte,
    input wire logic [15:0] rd_ea,
    input wire logic wr_req,
    input wire logic wr_byte,
    input wire logic [15:0] wr_ea,
    input wire logic [15:0] wr_data,
    output logic [23:0] pmem_addr,
    output logic pmem_rd,
    output logic pmem_wr,
    output logic [15:0] pmem_wdata,
    output logic [22:0] pc_next,
    output logic [15:0] tbl_rdata,
    output logic tbl_rvalid,
    output logic tbl_fault,
    output logic in_vector_area,
    output logic in_primary_ivt,
    output logic in_alternate_ivt,
    output logic [15:0] rd_data,
    output logic rd_valid,
    output logic rd_psv,
    output logic [15:0] cfg_reg_a,
    output logic [15:0] cfg_reg_b,
    output logic [15:0] cfg_reg_c,
    output logic cfg_loaded
);
    // Program-memory data storage of this device is outside; config load is local
    logic [15:0] dmem [0:DMEM_WORDS-1];
    mad_load_t state;
    mad_load_t next_state;
    logic [15:0] cfg_word1;
    logic [1:0] tbl_pend;
    logic tbl_pend_upper;
    logic rd_pend;
    logic rd_pend_byte;
    logic rd_pend_odd;
    logic rd_pend_zero;
    logic rd_pend_psv;
    logic [15:0] rd_word_q;

    // Program-space address formation
    wire [23:0] pc_addr = {1'b0, pc[22:1], 1'b0};
    wire [23:0] tbl_addr = {table_page_register, tbl_offset[15:1], tbl_upper};
    wire tbl_cfg_space = table_page_register[TBLPG_CFG_BIT];
    wire [23:0] cfg1_addr = LARGE_MEM ? CFG_WORD1_LARGE : CFG_WORD1_SMALL;
    wire [23:0] cfg2_addr = LARGE_MEM ? CFG_WORD2_LARGE : CFG_WORD2_SMALL;
    wire [23:0] user_top = LARGE_MEM ? CFG_WORD2_LARGE : CFG_WORD2_SMALL;
    wire [23:0] psv_addr = {1'b0, psv_page_addr[7:0], rd_ea[14:1], 1'b0};
    // Busy from reset until both words are in, so nothing else reaches the port
    wire loading = (state != MAD_LOAD_DONE);
    // One strobe per word: a held strobe would let a stale answer pose as word two
    wire load_first = (state == MAD_LOAD_IDLE);
    wire load_second = (state == MAD_LOAD_W1) && pmem_rvalid;
    wire load_on_w2 = load_second || (state == MAD_LOAD_W2);
    // Past the last implemented word, user space reads zero
    wire tbl_unimpl = !tbl_cfg_space && (tbl_addr > user_top);
    wire tbl_ok = tbl_cfg_space || (tbl_addr <= USER_TOP);
    wire psv_en = cpu_control_register[CPUCTL_VIS_BIT];

    // Independent read and write units
    wire r_ram;
    wire r_psv;
    wire r_none;
    wire [11:0] r_idx;
    wire w_ram;
    wire [11:0] w_idx;
    mad_data_agu u_rd_agu (
        .ea(rd_ea),
        .valid(rd_req),
        .psv_en(psv_en),
        .hit_ram(r_ram),
        .hit_psv(r_psv),
        .hit_none(r_none),
        .word_idx(r_idx)
    );
    mad_data_agu u_wr_agu (
        .ea(wr_ea),
        .valid(wr_req),
        .psv_en(psv_en),
        .hit_ram(w_ram),
        .hit_psv(),
        .hit_none(),
        .word_idx(w_idx)
    );

    wire [15:0] rd_word = rd_pend_zero ? 16'h0000 :
                          rd_pend_psv ? pmem_rdata[15:0] : rd_word_q;
    wire [15:0] rd_sel;
    mad_byte_lane u_lane (
        .word_in(rd_word),
        .byte_op(rd_pend_byte),
        .odd_addr(rd_pend_odd),
        .data_out(rd_sel)
    );

    // Next PC: steps of two, reset entry at zero
    wire [23:0] pc_fwd = pc_addr + PC_STEP;
    wire [23:0] pc_rev = pc_addr - PC_STEP;
    wire [22:0] next_pc = pc_load ? {pc_load_value[22:1], 1'b0} :
                          pc_advance ? pc_fwd[22:0] :
                          pc_back ? pc_rev[22:0] : pc_addr[22:0];

    // Program memory port: config load first, then window, table, fetch
    // Table ops yield the port to the config load and to window reads
    wire tbl_rd_take = !loading && !r_psv && tbl_req && !tbl_write && tbl_ok;
    wire tbl_rd_go = tbl_rd_take && !tbl_unimpl;
    wire tbl_wr_go = !loading && !r_psv && tbl_req && tbl_write && tbl_ok && !tbl_unimpl;
    wire tbl_bad = tbl_req && !loading && !tbl_ok;
    wire [23:0] next_pmem_addr = load_on_w2 ? cfg2_addr :
                                 loading ? cfg1_addr :
                                 r_psv ? psv_addr :
                                 tbl_req ? tbl_addr : pc_addr;
    wire next_pmem_rd = load_first || load_second || (!loading && r_psv) || tbl_rd_go;
    wire next_pmem_wr = tbl_wr_go;

    always_comb begin
        next_state = state;
        case (state)
            MAD_LOAD_IDLE: next_state = MAD_LOAD_W1;
            MAD_LOAD_W1: if (pmem_rvalid) next_state = MAD_LOAD_W2;
            MAD_LOAD_W2: if (pmem_rvalid) next_state = MAD_LOAD_DONE;
            default: next_state = MAD_LOAD_DONE;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= MAD_LOAD_IDLE;
            cfg_word1 <= CFG1_RESET;
        end else begin
            state <= next_state;
            if (state == MAD_LOAD_W1 && pmem_rvalid) cfg_word1 <= pmem_rdata[15:0];
        end
    end

    // Configuration registers: packed bits scattered in a fixed order
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg_reg_a <= CFG1_RESET;
            cfg_reg_b <= CFG2_RESET;
            cfg_reg_c <= CFG2_RESET;
            cfg_loaded <= 1'b0;
        end else if (state == MAD_LOAD_W2 && pmem_rvalid) begin
            cfg_reg_a <= {cfg_word1[7:0], pmem_rdata[15:8]};
            cfg_reg_b <= {pmem_rdata[7:0], cfg_word1[15:8]};
            cfg_reg_c <= {cfg_word1[3:0], pmem_rdata[3:0], cfg_word1[11:4]};
            cfg_loaded <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pmem_addr <= RESET_ADDR;
            pmem_rd <= 1'b0;
            pmem_wr <= 1'b0;
            pmem_wdata <= 16'h0000;
            pc_next <= 23'h000000;
        end else begin
            pmem_addr <= next_pmem_addr;
            pmem_rd <= next_pmem_rd;
            pmem_wr <= next_pmem_wr;
            pmem_wdata <= tbl_wdata;
            pc_next <= cfg_loaded ? next_pc : RESET_ADDR[22:0];
        end
    end

    // Vector region flags for the fetch unit
    wire next_in_vec = pc_addr < VECTOR_END;
    wire next_in_ivt = (pc_addr >= IVT_START) && (pc_addr <= IVT_END);
    wire next_in_aivt = (pc_addr >= AIVT_START) && (pc_addr <= AIVT_END);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            in_vector_area <= 1'b1;
            in_primary_ivt <= 1'b0;
            in_alternate_ivt <= 1'b0;
        end else begin
            in_vector_area <= next_in_vec;
            in_primary_ivt <= next_in_ivt;
            in_alternate_ivt <= next_in_aivt;
        end
    end

    // Table read answer follows the program memory's valid; unimplemented addresses answer zero without it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tbl_pend <= 2'b00;
            tbl_pend_upper <= 1'b0;
            tbl_rdata <= 16'h0000;
            tbl_rvalid <= 1'b0;
            tbl_fault <= 1'b0;
        end else begin
            tbl_fault <= tbl_bad;
            tbl_rvalid <= 1'b0;
            if (tbl_rd_take) begin
                tbl_pend <= tbl_unimpl ? 2'b10 : 2'b01;
                tbl_pend_upper <= tbl_upper;
            end else if (tbl_pend == 2'b10) begin
                tbl_pend <= 2'b00;
                tbl_rdata <= 16'h0000;
                tbl_rvalid <= 1'b1;
            end else if (tbl_pend == 2'b01 && pmem_rvalid) begin
                tbl_pend <= 2'b00;
                // Upper word carries bits 23:16; its top byte reads zero
                tbl_rdata <= tbl_pend_upper ? {8'h00, pmem_rdata[23:16]} :
                             pmem_rdata[15:0];
                tbl_rvalid <= 1'b1;
            end
        end
    end

    // A window read stays pending until program memory answers
    wire rd_take = rd_req && !loading;
    wire rd_hold = rd_pend && rd_pend_psv && !pmem_rvalid;

    // Data RAM: byte lanes written separately, no reset on storage
    // A byte write leaves the other lane of the word untouched
    always_ff @(posedge clk) begin
        if (w_ram) begin
            if (!wr_byte || !wr_ea[0]) dmem[w_idx][7:0] <= wr_byte ? wr_data[7:0] : wr_data[7:0];
            if (!wr_byte || wr_ea[0]) dmem[w_idx][15:8] <= wr_byte ? wr_data[7:0] : wr_data[15:8];
        end
        if (r_ram) rd_word_q <= dmem[r_idx];
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_pend <= 1'b0;
            rd_pend_byte <= 1'b0;
            rd_pend_odd <= 1'b0;
            rd_pend_zero <= 1'b0;
            rd_pend_psv <= 1'b0;
        end else begin
            rd_pend <= rd_take || rd_hold;
            if (rd_take) begin
                rd_pend_byte <= rd_byte;
                rd_pend_odd <= rd_ea[0];
                rd_pend_zero <= r_none;
                rd_pend_psv <= r_psv;
            end
        end
    end

    // Window reads finish when program memory answers; RAM reads one cycle later
    wire rd_done = rd_pend && (!rd_pend_psv || pmem_rvalid);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_data <= 16'h0000;
            rd_valid <= 1'b0;
            rd_psv <= 1'b0;
        end else begin
            rd_valid <= rd_done;
            rd_psv <= rd_done && rd_pend_psv;
            if (rd_done) rd_data <= rd_sel;
        end
    end
endmodule

// ==== mad_decoder_props.sv ====
// Port checks for the address-space decoder
`timescale 1ns/10ps
module mad_props
    import mad_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [22:0] pc,
    input wire logic pc_advance,
    input wire logic pc_load,
    input wire logic [15:0] cpu_control_register,
    input wire logic pmem_rvalid,
    input wire logic rd_req,
    input wire logic [15:0] rd_ea,
    input wire logic pmem_rd,
    input wire logic [22:0] pc_next,
    input wire logic in_vector_area,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid,
    input wire logic rd_psv,
    input wire logic cfg_loaded
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic [22:0] pa;
    logic rq;
    logic vis;
    assign pa = {pc[22:1], 1'b0};
    // Requests before the load completes are ignored, so they are not judged
    assign rq = cfg_loaded && rd_req;
    assign vis = cpu_control_register[CPUCTL_VIS_BIT];
    property p_step;
        cfg_loaded && pc_advance && !pc_load |=> pc_next == $past(pa) + 23'h000002;
    endproperty
    a_step: assert property (p_step) else $error("pc did not step by two");
    property p_start;
        $rose(cfg_loaded) |-> pc_next == 23'h000000;
    endproperty
    a_start: assert property (p_start) else $error("pc not at zero after load");
    property p_vec;
        1'b1 |=> in_vector_area == ($past(pa) < 23'h000200);
    endproperty
    a_vec: assert property (p_vec) else $error("vector area flag wrong");
    property p_ram;
        rq && !rd_ea[EA_PSV_BIT] |-> ##2 rd_valid;
    endproperty
    a_ram: assert property (p_ram) else $error("data read answer late");
    property p_zero;
        rq && rd_ea > DATA_IMPL_TOP && !(rd_ea[EA_PSV_BIT] && vis) |-> ##2 rd_valid && rd_data == 16'h0000;
    endproperty
    a_zero: assert property (p_zero) else $error("unimplemented read not zero");
    property p_nowin;
        rq && rd_ea[EA_PSV_BIT] && !vis |=> !rd_psv [*2];
    endproperty
    a_nowin: assert property (p_nowin) else $error("window used while disabled");
    property p_win;
        rq && rd_ea[EA_PSV_BIT] && vis |-> ##[1:4] pmem_rd;
    endproperty
    a_win: assert property (p_win) else $error("window read did not reach memory");
    property p_cfg;
        $rose(cfg_loaded) |-> $past(pmem_rvalid);
    endproperty
    a_cfg: assert property (p_cfg) else $error("load done without memory answer");
    c_win: cover property (rq && rd_ea[EA_PSV_BIT] && vis);
    c_zero: cover property (rq && rd_ea > DATA_IMPL_TOP);
    c_load: cover property ($rose(cfg_loaded));
endmodule
bind mad_decoder mad_props u_props (
    .clk, .rstn, .pc, .pc_advance, .pc_load, .cpu_control_register, .pmem_rvalid,
    .rd_req, .rd_ea, .pmem_rd, .pc_next, .in_vector_area, .rd_data, .rd_valid,
    .rd_psv, .cfg_loaded
);

// ==== mad_pmem_model.sv ====
// Program memory model answering the decoder's read strobes
`timescale 1ns/10ps
module mad_pmem_model
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic slow,
    input wire logic [23:0] pmem_addr,
    input wire logic pmem_rd,
    output logic [23:0] pmem_rdata,
    output logic pmem_rvalid
);
    logic [23:0] addr_q;
    logic [3:0] cnt;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 4'h0;
            addr_q <= 24'h000000;
            pmem_rvalid <= 1'b0;
            pmem_rdata <= 24'h000000;
        end else begin
            pmem_rvalid <= cnt == 4'h1;
            // Data flips every cycle between answers so a sample an odd number of cycles late never looks right
            pmem_rdata <= cnt == 4'h1 ? {addr_q[7:0] ^ 8'h5A, addr_q[15:0] ^ 16'hC3C3} : ~pmem_rdata;
            if (pmem_rd) begin
                addr_q <= pmem_addr;
                cnt <= slow ? 4'h5 : 4'h1;
            end else if (cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule

// ==== memory_address_map_decoder_bench.sv ====
// Directed bench for the address-space decoder
`timescale 1ns/10ps
module memory_address_map_decoder_bench;
    import mad_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, slow = 1'b0, pc_advance = 1'b0, pc_back = 1'b0;
    logic pc_load = 1'b0, tbl_req = 1'b0, tbl_write = 1'b0, tbl_upper = 1'b0;
    logic rd_req = 1'b0, rd_byte = 1'b0, wr_req = 1'b0, wr_byte = 1'b0;
    logic [22:0] pc = '0, pc_load_value = '0, pc_next;
    logic [7:0] table_page_register = '0;
    logic [15:0] tbl_offset = '0, tbl_wdata = '0, psv_page_addr = '0, cpu_control_register = '0;
    logic [15:0] rd_ea = '0, wr_ea = '0, wr_data = '0, pmem_wdata, tbl_rdata, rd_data, got;
    logic [15:0] cfg_reg_a, cfg_reg_b, cfg_reg_c;
    logic [23:0] pmem_rdata, pmem_addr;
    logic pmem_rvalid, pmem_rd, pmem_wr, tbl_rvalid, tbl_fault, rd_valid, rd_psv, cfg_loaded;
    logic in_vector_area, in_primary_ivt, in_alternate_ivt, got_psv;
    int num_errors = 0, compares = 0, cycles = 0;
    mad_decoder #(.LARGE_MEM(1'b1)) dut (
        .clk, .rstn, .pc, .pc_advance, .pc_back, .pc_load, .pc_load_value, .tbl_req,
        .tbl_write, .tbl_upper, .table_page_register, .tbl_offset, .tbl_wdata, .psv_page_addr,
        .cpu_control_register, .pmem_rdata, .pmem_rvalid, .rd_req, .rd_byte, .rd_ea, .wr_req,
        .wr_byte, .wr_ea, .wr_data, .pmem_addr, .pmem_rd, .pmem_wr, .pmem_wdata, .pc_next,
        .tbl_rdata, .tbl_rvalid, .tbl_fault, .in_vector_area, .in_primary_ivt,
        .in_alternate_ivt, .rd_data, .rd_valid, .rd_psv, .cfg_reg_a, .cfg_reg_b, .cfg_reg_c,
        .cfg_loaded
    );
    mad_pmem_model pm (.clk, .rstn, .slow, .pmem_addr, .pmem_rd, .pmem_rdata, .pmem_rvalid);
    initial forever #2 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            num_errors++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [23:0] act, input logic [23:0] exp);
        compares++;
        if (act !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h want %h", $time, act, exp);
        end
    endtask
    task automatic answer();
        int n;
        n = 0;
        while (rd_valid !== 1'b1 && tbl_rvalid !== 1'b1 && n < 30) begin
            @(negedge clk);
            n++;
        end
        got = (tbl_rvalid === 1'b1) ? tbl_rdata : rd_data;
        got_psv = rd_psv;
        chk(n < 30, 1'b1);
    endtask
    task automatic start();
        int n;
        n = 0;
        pc = '0;
        rstn = 1'b0;
        repeat (16) @(negedge clk);
        chk({cfg_reg_a, cfg_loaded, in_vector_area}, {16'hFFFF, 2'b01});
        rstn = 1'b1;
        while (cfg_loaded !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        chk({cfg_loaded, pc_next}, {1'b1, 23'h000000});
        // The model answers address-derived words, so a wrong word address shows here
        chk(cfg_reg_a, 16'h3F68);
        chk(cfg_reg_b, 16'h3D68);
        chk(cfg_reg_c, 16'hFD83);
    endtask
    task automatic step(input logic ld, adv, bk, input logic [22:0] v, exp);
        @(negedge clk);
        {pc_load, pc_advance, pc_back, pc_load_value} = {ld, adv, bk, v};
        @(negedge clk);
        {pc_load, pc_advance, pc_back} = 3'b000;
        chk(pc_next, exp);
        pc = pc_next;
    endtask
    task automatic vec(input logic [22:0] v, input logic [2:0] exp);
        @(negedge clk);
        pc = v;
        @(negedge clk);
        chk({in_vector_area, in_primary_ivt, in_alternate_ivt}, exp);
    endtask
    task automatic req(input logic [15:0] ea, input logic bw);
        @(negedge clk);
        {rd_ea, rd_byte, rd_req} = {ea, bw, 1'b1};
        @(negedge clk);
        rd_req = 1'b0;
        answer();
    endtask
    task automatic rd(input logic [15:0] ea, input logic bw, input logic [15:0] exp);
        req(ea, bw);
        chk(got, exp);
    endtask
    task automatic wr(input logic [15:0] ea, d, input logic bw);
        @(negedge clk);
        {wr_ea, wr_data, wr_byte, wr_req} = {ea, d, bw, 1'b1};
        @(negedge clk);
        wr_req = 1'b0;
    endtask
    task automatic tb(input logic [7:0] pg, input logic [15:0] off, input logic up, w,
                      input logic [15:0] exp);
        @(negedge clk);
        {table_page_register, tbl_offset, tbl_upper, tbl_write} = {pg, off, up, w};
        tbl_wdata = 16'h5AA5;
        tbl_req = 1'b1;
        @(negedge clk);
        tbl_req = 1'b0;
        if (w) begin
            // The write strobe stands only in the cycle after the request
            chk({pmem_wr, pmem_wdata}, {1'b1, 16'h5AA5});
            chk(pmem_addr, 24'h000200);
        end else begin
            answer();
            chk(got, exp);
        end
    endtask
    initial begin
        start();
        step(1'b1, 1'b0, 1'b0, 23'h000101, 23'h000100);
        step(1'b0, 1'b1, 1'b0, 23'h000000, 23'h000102);
        step(1'b0, 1'b1, 1'b1, 23'h000000, 23'h000104);
        step(1'b0, 1'b0, 1'b1, 23'h000000, 23'h000102);
        step(1'b1, 1'b1, 1'b0, 23'h000200, 23'h000200);
        vec(23'h000002, 3'b100);
        vec(23'h000004, 3'b110);
        vec(23'h0000FE, 3'b110);
        vec(23'h000100, 3'b101);
        vec(23'h0001FE, 3'b101);
        vec(23'h000200, 3'b000);
        wr(16'h0010, 16'hBEEF, 1'b0);
        rd(16'h0010, 1'b0, 16'hBEEF);
        wr(16'h0011, 16'h0012, 1'b1);
        rd(16'h0010, 1'b0, 16'h12EF);
        rd(16'h0011, 1'b1, 16'h0012);
        rd(16'h0010, 1'b1, 16'h00EF);
        wr(16'h1FFE, 16'hA55A, 1'b0);
        rd(16'h1FFE, 1'b0, 16'hA55A);
        wr(16'h0000, 16'h1111, 1'b0);
        wr(16'h2000, 16'h7777, 1'b0);
        rd(16'h0000, 1'b0, 16'h1111);
        rd(16'h2000, 1'b0, 16'h0000);
        rd(16'h8010, 1'b0, 16'h0000);
        slow = 1'b1;
        cpu_control_register = 16'h0004;
        req(16'h8010, 1'b0);
        chk(got_psv, 1'b1);
        chk(got, 16'hC3D3);
        tb(8'h00, 16'h0100, 1'b0, 1'b0, 16'hC2C3);
        tb(8'h00, 16'h0100, 1'b1, 1'b0, 16'h005B);
        tb(8'h80, 16'h0000, 1'b0, 1'b0, 16'hC3C3);
        tb(8'h00, 16'hF000, 1'b0, 1'b0, 16'h0000);
        tb(8'h00, 16'h0200, 1'b0, 1'b1, 16'h0000);
        start();
        print_verdict();
    end
endmodule
